// ### ber_ctrl_defs.svh
`ifndef BER_CTRL_DEFS_SVH
`define BER_CTRL_DEFS_SVH

// Register addresses on the management port
`define ADDR_OUTMODE   8'h1f
`define ADDR_SELMODE   8'h22
`define ADDR_ERRCTLA   8'h1e

// Field positions
`define OM_MODE_HI     2
`define OM_STDBY_BIT   4
`define OM_EN_BIT      5
`define SM_HOLD_BIT    1
`define SM_RATE_BIT    3
`define EA_START_BIT   3
`define EA_LEN_HI      7
`define EA_LEN_LO      5
`define EA_SEL_HI      2

// Output mode codes
`define MODE_NORMAL    3'h0
`define MODE_OFFSET     3'h1
`define MODE_DDR        3'h2
`define MODE_OFFSET_DDR 3'h3
`define MODE_PRBS      3'h5

// Measurement length base exponent and step
`define LEN_BASE_EXP   6'h12
`define LEN_STEP_EXP   6'h03
`define NUM_COUNT_BYTES 3'h5
`define LEN_MAX_CODE   3'h7
`define LEN_MAX_EXP    6'h27

// Reset values
`define REG_RESET      8'h00

`endif

// ### ber_ctrl_pkg.sv
package ber_ctrl_pkg;
  typedef enum logic [1:0] {
    MEAS_IDLE,
    MEAS_ARMED,
    MEAS_RUN
  } meas_state_t;
endpackage : ber_ctrl_pkg

// ### ber_monitor_output_mode_control.sv
`timescale 1ns/100ps
`default_nettype none
`include "ber_ctrl_defs.svh"

// Overview of operation
// (RULE_01) Output mode code 000 gives normal single data rate recovered data.
// (RULE_02) Output mode code 001 routes the offset decision path samples to the data output.
// (RULE_03) Output mode code 010 runs the outputs in double data rate mode.
// (RULE_04) Output mode code 011 gives offset decision path samples with double data rate timing.
// (RULE_05) Output mode code 101 in bits 2:0 enables the pattern generator and detector.
// (RULE_06) Bit 5 enables the error monitor and bit 4 places it in low-power standby.
// (RULE_07) A write of 1 then 0 to the start bit begins an error measurement.
// (RULE_08) Bits 7:5 set measurement length 2^18 to 2^39 bits and bits 2:0 pick a count byte.
// (RULE_09) Bit 1 of the mode select register enables clock holdover.
// (RULE_10) Bit 3 of the mode select register resets to 0 and enables limited-rate operation.
// (RULE_11) Software writes zero to unused bits and avoids reserved output mode codes.
module ber_monitor_output_mode_control
  import ber_ctrl_pkg::*;
(
  input  wire logic        ref_clk_in,       // System clock, 50 MHz
  input  wire logic        rst_in,           // Asynchronous reset, active high
  input  wire logic        wr_en_in,         // Register write strobe
  input  wire logic [7:0]  addr_in,          // Register address
  input  wire logic [7:0]  wdata_in,         // Register write data
  input  wire logic [39:0] error_count_in,   // Error count from the monitor
  output logic      [7:0]  rdata_out,        // Read data for addr_in
  output logic             normal_sdr_out,   // Normal data rate output
  output logic             offset_path_out,  // Offset decision path drives data
  output logic             ddr_enable_out,   // Double data rate timing
  output logic             prbs_enable_out,  // Pattern generator/detector enabled
  output logic             monitor_en_out,   // Error monitor enabled
  output logic             monitor_stdby_out, // Error monitor standby
  output logic             holdover_out,     // Clock holdover mode
  output logic             limited_rate_out, // Limited-rate loop operation
  output logic      [5:0]  meas_len_exp_out, // Measurement length exponent
  output logic             meas_start_out,   // One-cycle measurement start pulse
  output logic             measuring_out     // Measurement in progress
);

  ////////////////////////////////////////////////////////////////////////////
  // Register storage
  logic [7:0]  outmode_reg;
  logic [7:0]  selmode_reg;
  logic [7:0]  errctla_reg;
  meas_state_t state;
  meas_state_t next_state;

  // Decoded write strobes
  wire wr_outmode = wr_en_in && (addr_in == `ADDR_OUTMODE);
  wire wr_selmode = wr_en_in && (addr_in == `ADDR_SELMODE);
  wire wr_errctla = wr_en_in && (addr_in == `ADDR_ERRCTLA);

  // Register writes
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      outmode_reg <= `REG_RESET;
      selmode_reg <= `REG_RESET;            // [RULE_10]
      errctla_reg <= `REG_RESET;
    end else begin
      if (wr_outmode) outmode_reg <= wdata_in;
      if (wr_selmode) selmode_reg <= wdata_in;
      if (wr_errctla) errctla_reg <= wdata_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output mode decode
  wire [2:0] mode       = outmode_reg[`OM_MODE_HI:0];
  wire       m_normal   = (mode == `MODE_NORMAL);                          // [RULE_01]
  wire       m_offset   = (mode == `MODE_OFFSET) || (mode == `MODE_OFFSET_DDR); // [RULE_02] [RULE_04]
  wire       m_ddr      = (mode == `MODE_DDR) || (mode == `MODE_OFFSET_DDR);    // [RULE_03] [RULE_04]
  wire       m_prbs     = (mode == `MODE_PRBS);                            // [RULE_05]

  // Measurement length exponent: base plus three per code step
  wire [2:0] len_code   = errctla_reg[`EA_LEN_HI:`EA_LEN_LO];
  wire [5:0] len_exp    = `LEN_BASE_EXP + 6'(len_code) * `LEN_STEP_EXP;   // [RULE_08]

  // Start pulse: set bit then cleared bit
  wire start_bit        = errctla_reg[`EA_START_BIT];
  wire start_fall       = wr_errctla && start_bit && !wdata_in[`EA_START_BIT]; // [RULE_07]

  // Write that sets the start bit; arms the measurement from idle or from a run
  function automatic logic start_set(input logic wr, input logic [7:0] d);
    return wr && d[`EA_START_BIT];
  endfunction : start_set

  // Measurement state
  always_comb begin
    next_state = state;
    case (state)
      MEAS_IDLE:  if (start_set(wr_errctla, wdata_in)) next_state = MEAS_ARMED;  // [RULE_07]
      MEAS_ARMED: if (start_fall) next_state = MEAS_RUN;                        // [RULE_07]
      MEAS_RUN:   if (start_set(wr_errctla, wdata_in)) next_state = MEAS_ARMED;  // [RULE_07]
      default:    next_state = MEAS_IDLE;
    endcase
  end

  // Readback selection
  wire [7:0] count_byte;
  count_byte_select u_sel (
    .count_in (error_count_in),
    .sel_in   (errctla_reg[`EA_SEL_HI:0]), // [RULE_08]
    .byte_out (count_byte)
  );
  wire [7:0] rd_mux = (addr_in == `ADDR_OUTMODE) ? outmode_reg :
                      (addr_in == `ADDR_SELMODE) ? selmode_reg :
                      (addr_in == `ADDR_ERRCTLA) ? count_byte  : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state            <= MEAS_IDLE;
      rdata_out        <= 8'h00;
      normal_sdr_out   <= 1'b0;
      offset_path_out  <= 1'b0;
      ddr_enable_out   <= 1'b0;
      prbs_enable_out  <= 1'b0;
      monitor_en_out   <= 1'b0;
      monitor_stdby_out <= 1'b0;
      holdover_out     <= 1'b0;
      limited_rate_out <= 1'b0;
      meas_len_exp_out <= 6'h00;
      meas_start_out   <= 1'b0;
      measuring_out    <= 1'b0;
    end else begin
      state            <= next_state;
      rdata_out        <= rd_mux;
      normal_sdr_out   <= m_normal;                          // [RULE_01]
      offset_path_out  <= m_offset;                          // [RULE_02]
      ddr_enable_out   <= m_ddr;                             // [RULE_03]
      prbs_enable_out  <= m_prbs;                            // [RULE_05]
      monitor_en_out   <= outmode_reg[`OM_EN_BIT];           // [RULE_06]
      monitor_stdby_out <= outmode_reg[`OM_STDBY_BIT];       // [RULE_06]
      holdover_out     <= selmode_reg[`SM_HOLD_BIT];         // [RULE_09]
      limited_rate_out <= selmode_reg[`SM_RATE_BIT];         // [RULE_10]
      meas_len_exp_out <= len_exp;                           // [RULE_08]
      meas_start_out   <= start_fall;                        // [RULE_07]
      measuring_out    <= (next_state == MEAS_RUN);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  // Start handshake: a write that sets the start bit, then one that clears it
  sequence s_start_arm;
    wr_errctla && wdata_in[`EA_START_BIT];
  endsequence

  sequence s_start_clear;
    wr_errctla && !wdata_in[`EA_START_BIT];
  endsequence

  // Mode outputs follow the stored output mode code one edge later
  property p_normal;
    @(posedge ref_clk_in) disable iff (rst_in) (mode == `MODE_NORMAL) |=> normal_sdr_out;
  endproperty
  a_normal: assert property (p_normal) else $error("normal mode not shown"); // [RULE_01]

  property p_offset;
    @(posedge ref_clk_in) disable iff (rst_in) (mode == `MODE_OFFSET) |=> offset_path_out && !ddr_enable_out;
  endproperty
  a_offset: assert property (p_offset) else $error("offset path mode wrong"); // [RULE_02]

  property p_ddr;
    @(posedge ref_clk_in) disable iff (rst_in) (mode == `MODE_DDR) |=> ddr_enable_out && !offset_path_out;
  endproperty
  a_ddr: assert property (p_ddr) else $error("ddr mode wrong"); // [RULE_03]

  property p_offset_ddr;
    @(posedge ref_clk_in) disable iff (rst_in) (mode == `MODE_OFFSET_DDR) |=> ddr_enable_out && offset_path_out;
  endproperty
  a_offset_ddr: assert property (p_offset_ddr) else $error("offset path ddr mode wrong"); // [RULE_04]

  property p_prbs;
    @(posedge ref_clk_in) disable iff (rst_in) prbs_enable_out |-> $past(mode) == `MODE_PRBS;
  endproperty
  a_prbs: assert property (p_prbs) else $error("prbs enable without code"); // [RULE_05]

  property p_prbs_only;
    @(posedge ref_clk_in) disable iff (rst_in)
      (mode == `MODE_PRBS) |=> prbs_enable_out && !normal_sdr_out && !offset_path_out && !ddr_enable_out;
  endproperty
  a_prbs_only: assert property (p_prbs_only) else $error("prbs code sets other modes"); // [RULE_05]

  // Monitor control bits reach their outputs two edges after the write
  property p_mon;
    @(posedge ref_clk_in) disable iff (rst_in)
      wr_outmode |=> ##1 (monitor_en_out == $past(wdata_in[`OM_EN_BIT], 2)) &&
                         (monitor_stdby_out == $past(wdata_in[`OM_STDBY_BIT], 2));
  endproperty
  a_mon: assert property (p_mon) else $error("monitor control mismatch"); // [RULE_06]

  // Start pulse lasts one cycle and only follows a clearing write
  property p_start;
    @(posedge ref_clk_in) disable iff (rst_in) s_start_arm ##1 s_start_clear |=> meas_start_out ##1 !meas_start_out;
  endproperty
  a_start: assert property (p_start) else $error("start pulse missing"); // [RULE_07]

  property p_start_only;
    @(posedge ref_clk_in) disable iff (rst_in)
      meas_start_out |-> $past(wr_errctla) && !$past(wdata_in[`EA_START_BIT]);
  endproperty
  a_start_only: assert property (p_start_only) else $error("start pulse without clearing write"); // [RULE_07]

  property p_measuring;
    @(posedge ref_clk_in) disable iff (rst_in) s_start_arm ##1 s_start_clear |=> measuring_out;
  endproperty
  a_measuring: assert property (p_measuring) else $error("measurement not running"); // [RULE_07]

  // Longest measurement length code gives the largest exponent
  property p_len;
    @(posedge ref_clk_in) disable iff (rst_in)
      (len_code == `LEN_MAX_CODE) ##1 (len_code == `LEN_MAX_CODE) |-> meas_len_exp_out == `LEN_MAX_EXP;
  endproperty
  a_len: assert property (p_len) else $error("length exponent wrong"); // [RULE_08]

  // Mode select bits reach their outputs two edges after the write
  property p_hold;
    @(posedge ref_clk_in) disable iff (rst_in) wr_selmode |=> ##1 holdover_out == $past(wdata_in[`SM_HOLD_BIT], 2);
  endproperty
  a_hold: assert property (p_hold) else $error("holdover mismatch"); // [RULE_09]

  property p_rate_wr;
    @(posedge ref_clk_in) disable iff (rst_in)
      wr_selmode |=> ##1 limited_rate_out == $past(wdata_in[`SM_RATE_BIT], 2);
  endproperty
  a_rate_wr: assert property (p_rate_wr) else $error("limited rate mismatch"); // [RULE_10]

  property p_rate;
    @(posedge ref_clk_in) $fell(rst_in) |-> !limited_rate_out;
  endproperty
  a_rate: assert property (p_rate) else $error("limited rate not cleared"); // [RULE_10]

endmodule : ber_monitor_output_mode_control

`default_nettype wire

// ### ber_monitor_output_mode_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "ber_ctrl_defs.svh"

module ber_monitor_output_mode_control_tb;
  typedef struct {int kind; logic [7:0] val;} note_t;
  logic        ref_clk_in, rst_in, wr_en_in, meas_start_out, measuring_out;
  logic [7:0]  addr_in, wdata_in, rdata_out, om, sm, e;
  wire  [7:0]  flags;
  logic [39:0] error_count_in;
  logic [5:0]  meas_len_exp_out;
  logic [2:0]  len;
  logic [2:0]  codes [5];
  int          fail_count, n_compared, seed;
  note_t       q[$];
  note_t       n;

  ber_monitor_output_mode_control dut (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .wr_en_in(wr_en_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .error_count_in(error_count_in), .rdata_out(rdata_out),
    .normal_sdr_out(flags[7]), .offset_path_out(flags[6]), .ddr_enable_out(flags[5]),
    .prbs_enable_out(flags[4]), .monitor_en_out(flags[3]), .monitor_stdby_out(flags[2]),
    .holdover_out(flags[1]), .limited_rate_out(flags[0]), .meas_len_exp_out(meas_len_exp_out),
    .meas_start_out(meas_start_out), .measuring_out(measuring_out));

  ////////////////////////////////////////////////////////////////////////////////
  // Expected mode flags from the two shadow registers
  function automatic logic [7:0] exp_flags(input logic [7:0] o, input logic [7:0] s);
    exp_flags = {o[2:0] == 3'h0, o[2:0] == 3'h1 || o[2:0] == 3'h3, o[2:0] == 3'h2 || o[2:0] == 3'h3,
                 o[2:0] == 3'h5, o[5], o[4], s[1], s[3]};
  endfunction : exp_flags

  task automatic note(input int kind, input logic [7:0] val);
    q.push_back('{kind, val});
  endtask : note

  // Write is taken at the next edge; strobe stays up for back-to-back writes
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wr_en_in = 1'b1;
    addr_in  = a;
    wdata_in = d;
    @(posedge ref_clk_in);
    #2;
  endtask : wr

  task automatic tick;
    wr_en_in = 1'b0;
    @(posedge ref_clk_in);
    #2;
  endtask : tick

  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    wr_en_in = 1'b0;
    addr_in  = a;
    @(posedge ref_clk_in);
    #2;
    note(2, x);
  endtask : rd

  task automatic cmp_flags(input logic [7:0] got, input logic [7:0] x);
    n_compared++;
    if (got !== x) begin
      fail_count++;
      $display("mismatch at %0t: flags got %h want %h", $time, got, x);
    end
  endtask : cmp_flags

  task automatic cmp_len(input logic [5:0] got, input logic [5:0] x);
    n_compared++;
    if (got !== x) begin
      fail_count++;
      $display("mismatch at %0t: length exponent got %0d want %0d", $time, got, x);
    end
  endtask : cmp_len

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] x);
    n_compared++;
    if (got !== x) begin
      fail_count++;
      $display("mismatch at %0t: read data got %h want %h", $time, got, x);
    end
  endtask : cmp_byte

  task automatic cmp_meas(input logic [1:0] got, input logic [1:0] x);
    n_compared++;
    if (got !== x) begin
      fail_count++;
      $display("mismatch at %0t: start and measuring got %b want %b", $time, got, x);
    end
  endtask : cmp_meas

  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, watchdog and the monitor that retires notes
  initial begin
    ref_clk_in = 1'b0;
    forever #10 ref_clk_in = ~ref_clk_in;
  end

  initial begin
    #200000;
    fail_count++;
    summarize;
  end

  initial forever begin
    @(posedge ref_clk_in);
    #5;
    while (q.size() > 0) begin
      n = q.pop_front();
      case (n.kind)
        0: cmp_flags(flags, n.val);
        1: cmp_len(meas_len_exp_out, n.val[5:0]);
        3: cmp_meas({meas_start_out, measuring_out}, n.val[1:0]);
        default: cmp_byte(rdata_out, n.val);
      endcase
    end
  end

  // Main sequence
  initial begin
    seed = 32'h2e66f3f5;
    fail_count = 0;
    n_compared = 0;
    om = 8'h00;
    sm = 8'h00;
    codes = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5};
    rst_in = 1'b1;
    wr_en_in = 1'b0;
    addr_in = 8'h00;
    wdata_in = 8'h00;
    error_count_in = 40'({$random(seed), $random(seed)});
    repeat (8) @(posedge ref_clk_in);
    #2 rst_in = 1'b0;
    tick;
    note(0, exp_flags(om, sm));
    note(1, 8'h12);
    rd(`ADDR_OUTMODE, 8'h00);
    rd(`ADDR_SELMODE, 8'h00);
    // Every legal output mode code in turn, with random monitor enable and standby
    for (int i = 0; i < 16; i++) begin
      om = {2'b00, 2'($random(seed)), 1'b0, codes[i % 5]};
      wr(`ADDR_OUTMODE, om);
      tick;
      note(0, exp_flags(om, sm));
      rd(`ADDR_OUTMODE, om);
    end
    // Back-to-back writes to mode select and output mode
    for (int i = 0; i < 4; i++) begin
      sm = {4'h0, i[1], 1'b0, i[0], 1'b0};
      om = {2'b00, 2'(i), 1'b0, codes[i + 1]};
      wr(`ADDR_SELMODE, sm);
      wr(`ADDR_OUTMODE, om);
      tick;
      note(0, exp_flags(om, sm));
    end
    // Length codes and count byte readback, out-of-range selects included
    for (int i = 0; i < 8; i++) begin
      error_count_in = 40'({$random(seed), $random(seed)});
      len = 3'(7 - i);
      wr(`ADDR_ERRCTLA, {len, 2'b00, 3'(i)});
      tick;
      note(1, 8'h12 + 8'h03 * len);
      e = (i < 5) ? error_count_in[8 * i +: 8] : 8'h00;
      rd(`ADDR_ERRCTLA, e);
    end
    // A clearing write alone must not start; 1 then 0 gives one pulse
    wr(`ADDR_ERRCTLA, 8'h00);
    tick;
    note(3, 8'h00);
    wr(`ADDR_ERRCTLA, 8'h08);
    wr(`ADDR_ERRCTLA, 8'h00);
    note(3, 8'h03);
    tick;
    note(3, 8'h01);
    // Unmapped address reads zero and a write there changes nothing
    rd(8'h55, 8'h00);
    wr(8'h55, 8'hff);
    tick;
    note(0, exp_flags(om, sm));
    tick;
    summarize;
  end
endmodule : ber_monitor_output_mode_control_tb
`default_nettype wire

// ### count_byte_select.sv
`timescale 1ns/100ps
`default_nettype none
`include "ber_ctrl_defs.svh"

// Selects one byte of the 40-bit error count for readback
module count_byte_select (
  input  wire logic [39:0] count_in, // Error count
  input  wire logic [2:0]  sel_in,   // Byte index
  output logic      [7:0]  byte_out  // Selected byte, zero when out of range
);
  logic [7:0] bytes [0:4];
  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : g_byte
      assign bytes[g] = count_in[8*g +: 8];
    end
  endgenerate
  assign byte_out = (sel_in < `NUM_COUNT_BYTES) ? bytes[sel_in] : 8'h00;
endmodule : count_byte_select

`default_nettype wire
